// *** src/atc_map.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the
//          front-end trim and timing block
// Assumes: 25 MHz core clock; register index times four gives the byte address
// Notes:   definitions only
//
// Summary of operation
// - gain update strobe fires for both channels every period count times 2 us
// - gain update period of zero stops all periodic gain updates
// - coarse override bit 15 disables auto offset, drives DAC from bits 7:0
// - fine override bit 15 disables auto offset, drives DAC from bits 7:0
// - forced offset codes are signed two's complement, 250 uV per step
// - offset update strobe fires for both channels every period count times 2 us
// - offset update period of zero stops all periodic offset updates
// - extrapolator runs count times 2 us after each qualifying event
// - extrapolation run time of zero never activates the extrapolator
// - sleep exit waits the 16-bit settle cycle count before going functional
// - startup holds digital sequencing in reset for the 19-bit split cycle count plus one cycle
// - startup count resets to 0x0006 / 0x1a80; other registers reset to zero
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// register indices
`define ATC_IDX_GAIN_PERIOD 8'h44
`define ATC_IDX_COARSE_OVR 8'h45
`define ATC_IDX_FINE_OVR 8'h46
`define ATC_IDX_OFFSET_PERIOD 8'h47
`define ATC_IDX_EXTRAP_TIME 8'h48
`define ATC_IDX_SLEEP_SETTLE 8'h4c
`define ATC_IDX_STARTUP_UPPER 8'h4d
`define ATC_IDX_STARTUP_LOWER 8'h4e

// field positions
`define ATC_OVR_EN_BIT 15
`define ATC_OVR_CODE_MSB 7
`define ATC_STARTUP_UPPER_MSB 2

// reset values
`define ATC_RST_ZERO 16'h0000
`define ATC_RST_STARTUP_UPPER 3'h6
`define ATC_RST_STARTUP_LOWER 16'h1a80

// timing: one period unit is 2 us
`define ATC_UNIT_NS 2000
`define ATC_CLK_NS 40
`define ATC_UNIT_CYCLES ((`ATC_UNIT_NS) / (`ATC_CLK_NS))

`endif

// *** src/atc_period_timer.sv ***
// Purpose: periodic strobe every period_i units of PRESCALE clocks
// Assumes: period_i comes from a register on the same clock
// Notes:   a zero period stops the strobe entirely
`timescale 1ns/1ps
`default_nettype none
`include "atc_map.svh"

module atc_period_timer #(
	parameter int unsigned PRESCALE = `ATC_UNIT_CYCLES,
	parameter int unsigned PW = 16
) (
	input wire logic clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire logic [PW-1:0] period_i, // period in units
	input wire logic restart_i, // period register written
	output logic tick_o // one-cycle update strobe
);
	localparam int unsigned SW = $clog2(PRESCALE + 1);

	logic [SW-1:0] presc_ff;
	logic [PW-1:0] unit_ff;
	logic tick_ff;
	logic presc_end;
	logic period_zero;

	assign presc_end = (presc_ff == SW'(PRESCALE - 1));
	assign period_zero = (period_i == '0);
	assign tick_o = tick_ff;

	// -------------------------------------------------------------
	// prescaler and unit counter
	// -------------------------------------------------------------
	// restart on write so a new period counts from a clean interval
	always_ff @(posedge clk_i)
	begin
		if (srst_i || restart_i || period_zero)
		begin
			presc_ff <= '0;
			unit_ff <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= 1'b0;
			if (presc_end)
			begin
				presc_ff <= '0;
				if (unit_ff == period_i - PW'(1))
				begin
					unit_ff <= '0;
					tick_ff <= 1'b1;
				end
				else
				begin
					unit_ff <= unit_ff + PW'(1);
				end
			end
			else
			begin
				presc_ff <= presc_ff + SW'(1);
			end
		end
	end

	// -------------------------------------------------------------
	// checking helpers
	// -------------------------------------------------------------
	logic [31:0] gap_ff;
	logic steady_ff;

	always_ff @(posedge clk_i)
	begin
		if (srst_i || restart_i || period_zero || tick_ff)
			gap_ff <= '0;
		else
			gap_ff <= gap_ff + 32'd1;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i || restart_i || period_zero)
			steady_ff <= 1'b0;
		else if (tick_ff)
			steady_ff <= 1'b1;
	end

	a_tick_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
		tick_ff && steady_ff |-> gap_ff == 32'(period_i) * 32'(PRESCALE) - 32'd1)
		else $error("update strobe spacing wrong");

	a_zero_no_tick: assert property (@(posedge clk_i) disable iff (srst_i)
		$past(period_zero) |-> !tick_ff)
		else $error("strobe with zero period");
endmodule // atc_period_timer

`default_nettype wire

// *** src/atc_pkg.sv ***
// Purpose: shared types of the front-end trim and timing block
// Assumes: constants live in atc_map.svh
// Notes:   one-hot state codes
package atc_pkg;
	typedef enum logic [1:0] {
		ATC_ST_HOLD = 2'b01,
		ATC_ST_RUN = 2'b10
	} atc_start_e;

	typedef enum logic [1:0] {
		ATC_WK_IDLE = 2'b01,
		ATC_WK_SETTLE = 2'b10
	} atc_wake_e;

	typedef logic signed [7:0] atc_offset_t;
	typedef logic [7:0] atc_idx_t;
endpackage

// *** src/atc_top.sv ***
// Purpose: front-end trim and timing registers with update timers,
//          offset overrides, extrapolator run window and settle delays
// Assumes: Avalon-MM slave, byte addresses, registers at index times four
// Notes:   all outputs are registered; answer comes one cycle after request
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "atc_map.svh"

module atc_top #(
	parameter int unsigned PRESCALE = `ATC_UNIT_CYCLES,
	parameter logic [18:0] STARTUP_RESET_CNT =
		{`ATC_RST_STARTUP_UPPER, `ATC_RST_STARTUP_LOWER}
) (
	input wire logic clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire logic [9:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall, high
	input wire atc_pkg::atc_offset_t coarse_auto_code_i, // auto coarse offset
	input wire atc_pkg::atc_offset_t fine_auto_code_i, // auto fine offset
	input wire logic qualify_evt_i, // extrapolator trigger
	input wire logic sleep_exit_i, // leaving sleep, pulse
	output logic gain_update_stb_o, // gain DAC update strobe
	output logic offset_update_stb_o, // offset DAC update strobe
	output logic coarse_auto_en_o, // coarse auto offset on
	output logic fine_auto_en_o, // fine auto offset on
	output atc_pkg::atc_offset_t coarse_offset_dac_o, // coarse DAC code
	output atc_pkg::atc_offset_t fine_offset_dac_o, // fine DAC code
	output logic extrap_active_o, // extrapolator running
	output logic wake_settling_o, // sleep exit settle busy
	output logic wake_done_o, // functional, pulse
	output logic dsp_hold_o // startup hold of sequencing
);
	import atc_pkg::*;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic atc_idx_t reg_index(input logic [9:0] addr);
		reg_index = addr[9:2];
	endfunction

	// merge the two low byte lanes into a 16-bit register
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		lane_merge = {be[1] ? new_v[15:8] : old_v[15:8],
			be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	logic [15:0] gain_update_period_ff;
	logic coarse_offset_force_en_ff;
	logic [7:0] coarse_offset_forced_code_ff;
	logic fine_offset_force_en_ff;
	logic [7:0] fine_offset_forced_code_ff;
	logic [15:0] offset_update_period_ff;
	logic [15:0] extrapolation_run_time_ff;
	logic [15:0] sleep_exit_settle_cycles_ff;
	logic [2:0] startup_upper_ff;
	logic [15:0] startup_lower_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic wr_take;
	logic [15:0] wdata;
	logic [15:0] ovr_old_c;
	logic [15:0] ovr_old_f;
	logic [15:0] ovr_new_c;
	logic [15:0] ovr_new_f;
	logic [15:0] up_new;
	atc_idx_t idx;

	assign idx = reg_index(avs_address_i);
	assign wdata = avs_writedata_i[15:0];
	assign wr_take = avs_write_i && !wait_ff;
	assign avs_waitrequest_o = wait_ff;
	assign avs_readdata_o = rdata_ff;
	assign ovr_old_c = {coarse_offset_force_en_ff, 7'h00, coarse_offset_forced_code_ff};
	assign ovr_old_f = {fine_offset_force_en_ff, 7'h00, fine_offset_forced_code_ff};
	assign ovr_new_c = lane_merge(ovr_old_c, wdata, avs_byteenable_i[1:0]);
	assign ovr_new_f = lane_merge(ovr_old_f, wdata, avs_byteenable_i[1:0]);
	assign up_new = lane_merge({13'h0000, startup_upper_ff}, wdata, avs_byteenable_i[1:0]);

	// wait one cycle, then answer; back to waiting after each answer
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			wait_ff <= 1'b1;
		else
			wait_ff <= !((avs_read_i || avs_write_i) && wait_ff);
	end

	// register writes; unmapped writes are dropped
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			gain_update_period_ff <= `ATC_RST_ZERO;
			coarse_offset_force_en_ff <= 1'b0;
			coarse_offset_forced_code_ff <= 8'h00;
			fine_offset_force_en_ff <= 1'b0;
			fine_offset_forced_code_ff <= 8'h00;
			offset_update_period_ff <= `ATC_RST_ZERO;
			extrapolation_run_time_ff <= `ATC_RST_ZERO;
			sleep_exit_settle_cycles_ff <= `ATC_RST_ZERO;
			startup_upper_ff <= STARTUP_RESET_CNT[18:16];
			startup_lower_ff <= STARTUP_RESET_CNT[15:0];
		end
		else if (wr_take)
		begin
			unique case (idx)
				`ATC_IDX_GAIN_PERIOD:
					gain_update_period_ff <= lane_merge(gain_update_period_ff, wdata, avs_byteenable_i[1:0]);
				`ATC_IDX_COARSE_OVR:
				begin
					coarse_offset_force_en_ff <= ovr_new_c[`ATC_OVR_EN_BIT];
					coarse_offset_forced_code_ff <= ovr_new_c[`ATC_OVR_CODE_MSB:0];
				end
				`ATC_IDX_FINE_OVR:
				begin
					fine_offset_force_en_ff <= ovr_new_f[`ATC_OVR_EN_BIT];
					fine_offset_forced_code_ff <= ovr_new_f[`ATC_OVR_CODE_MSB:0];
				end
				`ATC_IDX_OFFSET_PERIOD:
					offset_update_period_ff <= lane_merge(offset_update_period_ff, wdata, avs_byteenable_i[1:0]);
				`ATC_IDX_EXTRAP_TIME:
					extrapolation_run_time_ff <= lane_merge(extrapolation_run_time_ff, wdata, avs_byteenable_i[1:0]);
				`ATC_IDX_SLEEP_SETTLE:
					sleep_exit_settle_cycles_ff <= lane_merge(sleep_exit_settle_cycles_ff, wdata, avs_byteenable_i[1:0]);
				`ATC_IDX_STARTUP_UPPER:
					startup_upper_ff <= up_new[`ATC_STARTUP_UPPER_MSB:0];
				`ATC_IDX_STARTUP_LOWER:
					startup_lower_ff <= lane_merge(startup_lower_ff, wdata, avs_byteenable_i[1:0]);
				default:
				begin
				end
			endcase
		end
	end

	// read mux; reserved and unmapped bits read zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		unique case (idx)
			`ATC_IDX_GAIN_PERIOD: nxt_rdata[15:0] = gain_update_period_ff;
			`ATC_IDX_COARSE_OVR: nxt_rdata[15:0] = ovr_old_c;
			`ATC_IDX_FINE_OVR: nxt_rdata[15:0] = ovr_old_f;
			`ATC_IDX_OFFSET_PERIOD: nxt_rdata[15:0] = offset_update_period_ff;
			`ATC_IDX_EXTRAP_TIME: nxt_rdata[15:0] = extrapolation_run_time_ff;
			`ATC_IDX_SLEEP_SETTLE: nxt_rdata[15:0] = sleep_exit_settle_cycles_ff;
			`ATC_IDX_STARTUP_UPPER: nxt_rdata[2:0] = startup_upper_ff;
			`ATC_IDX_STARTUP_LOWER: nxt_rdata[15:0] = startup_lower_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// capture during the wait cycle so data stands at the answer edge
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_ff <= 32'h0000_0000;
		else if (avs_read_i && wait_ff)
			rdata_ff <= nxt_rdata;
	end

	a_bus_one_wait: assert property (@(posedge clk_i) disable iff (srst_i)
		(avs_read_i || avs_write_i) && wait_ff |=> !wait_ff ##1 wait_ff)
		else $error("bus answer timing wrong");

	// -------------------------------------------------------------
	// gain and offset update timers
	// -------------------------------------------------------------
	logic gain_restart;
	logic offset_restart;

	assign gain_restart = wr_take && (idx == `ATC_IDX_GAIN_PERIOD);
	assign offset_restart = wr_take && (idx == `ATC_IDX_OFFSET_PERIOD);

	// one strobe serves both channels
	atc_period_timer #(.PRESCALE(PRESCALE), .PW(16)) u_gain_timer (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.period_i(gain_update_period_ff),
		.restart_i(gain_restart),
		.tick_o(gain_update_stb_o)
	);

	atc_period_timer #(.PRESCALE(PRESCALE), .PW(16)) u_offset_timer (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.period_i(offset_update_period_ff),
		.restart_i(offset_restart),
		.tick_o(offset_update_stb_o)
	);

	// -------------------------------------------------------------
	// offset overrides
	// -------------------------------------------------------------
	logic coarse_auto_en_ff;
	logic fine_auto_en_ff;
	atc_offset_t coarse_dac_ff;
	atc_offset_t fine_dac_ff;

	assign coarse_auto_en_o = coarse_auto_en_ff;
	assign fine_auto_en_o = fine_auto_en_ff;
	assign coarse_offset_dac_o = coarse_dac_ff;
	assign fine_offset_dac_o = fine_dac_ff;

	// forced code is passed as signed, 250 uV per lsb
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			coarse_auto_en_ff <= 1'b1;
			fine_auto_en_ff <= 1'b1;
			coarse_dac_ff <= '0;
			fine_dac_ff <= '0;
		end
		else
		begin
			coarse_auto_en_ff <= !coarse_offset_force_en_ff;
			fine_auto_en_ff <= !fine_offset_force_en_ff;
			coarse_dac_ff <= coarse_offset_force_en_ff ?
				atc_offset_t'(coarse_offset_forced_code_ff) : coarse_auto_code_i;
			fine_dac_ff <= fine_offset_force_en_ff ?
				atc_offset_t'(fine_offset_forced_code_ff) : fine_auto_code_i;
		end
	end

	a_coarse_forced: assert property (@(posedge clk_i) disable iff (srst_i)
		$past(coarse_offset_force_en_ff) && !$past(srst_i) |->
		!coarse_auto_en_o && coarse_offset_dac_o == $past(coarse_offset_forced_code_ff))
		else $error("coarse override not applied");

	a_fine_forced: assert property (@(posedge clk_i) disable iff (srst_i)
		$past(fine_offset_force_en_ff) && !$past(srst_i) |->
		!fine_auto_en_o && fine_offset_dac_o == $past(fine_offset_forced_code_ff))
		else $error("fine override not applied");

	// -------------------------------------------------------------
	// extrapolator run window
	// -------------------------------------------------------------
	localparam int unsigned XSW = $clog2(PRESCALE + 1);
	logic [XSW-1:0] x_presc_ff;
	logic [15:0] x_unit_ff;
	logic extrap_ff;
	logic x_unit_end;

	assign x_unit_end = (x_presc_ff == XSW'(PRESCALE - 1));
	assign extrap_active_o = extrap_ff;

	// a new event while running restarts the window
	always_ff @(posedge clk_i)
	begin
		if (srst_i || extrapolation_run_time_ff == 16'h0000)
		begin
			extrap_ff <= 1'b0;
			x_presc_ff <= '0;
			x_unit_ff <= 16'h0000;
		end
		else if (qualify_evt_i)
		begin
			extrap_ff <= 1'b1;
			x_presc_ff <= '0;
			x_unit_ff <= 16'h0000;
		end
		else if (extrap_ff)
		begin
			if (x_unit_end)
			begin
				x_presc_ff <= '0;
				if (x_unit_ff == extrapolation_run_time_ff - 16'h0001)
					extrap_ff <= 1'b0;
				else
					x_unit_ff <= x_unit_ff + 16'h0001;
			end
			else
			begin
				x_presc_ff <= x_presc_ff + XSW'(1);
			end
		end
	end

	a_extrap_start: assert property (@(posedge clk_i) disable iff (srst_i)
		qualify_evt_i && extrapolation_run_time_ff != 16'h0000 |=> extrap_active_o)
		else $error("extrapolator did not start");

	a_extrap_zero: assert property (@(posedge clk_i) disable iff (srst_i)
		$past(extrapolation_run_time_ff == 16'h0000) |-> !extrap_active_o)
		else $error("extrapolator ran with zero time");

	// -------------------------------------------------------------
	// sleep exit settle
	// -------------------------------------------------------------
	atc_wake_e wake_st_ff;
	logic [15:0] wake_cnt_ff;
	logic wake_done_ff;

	assign wake_settling_o = wake_st_ff[1]; // one-hot settle bit, straight from the flop
	assign wake_done_o = wake_done_ff;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wake_st_ff <= ATC_WK_IDLE;
			wake_cnt_ff <= 16'h0000;
			wake_done_ff <= 1'b0;
		end
		else
		begin
			wake_done_ff <= 1'b0;
			unique case (wake_st_ff)
				ATC_WK_IDLE:
				begin
					if (sleep_exit_i && sleep_exit_settle_cycles_ff == 16'h0000)
						wake_done_ff <= 1'b1;
					else if (sleep_exit_i)
					begin
						wake_st_ff <= ATC_WK_SETTLE;
						wake_cnt_ff <= 16'h0001;
					end
				end
				ATC_WK_SETTLE:
				begin
					if (wake_cnt_ff >= sleep_exit_settle_cycles_ff)
					begin
						wake_st_ff <= ATC_WK_IDLE;
						wake_done_ff <= 1'b1;
					end
					else
					begin
						wake_cnt_ff <= wake_cnt_ff + 16'h0001;
					end
				end
			endcase
		end
	end

	a_wake_settle: assert property (@(posedge clk_i) disable iff (srst_i)
		wake_settling_o && wake_cnt_ff < sleep_exit_settle_cycles_ff |=>
		wake_settling_o && !wake_done_o)
		else $error("settle ended early");

	// -------------------------------------------------------------
	// startup hold
	// -------------------------------------------------------------
	atc_start_e start_st_ff;
	logic [18:0] start_cnt_ff;

	// the limit is read live, so software may stretch the hold
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			start_st_ff <= ATC_ST_HOLD;
			start_cnt_ff <= 19'h00000;
			dsp_hold_o <= 1'b1;
		end
		else
		begin
			unique case (start_st_ff)
				ATC_ST_HOLD:
				begin
					if (start_cnt_ff >= {startup_upper_ff, startup_lower_ff})
					begin
						start_st_ff <= ATC_ST_RUN;
						dsp_hold_o <= 1'b0;
					end
					else
					begin
						start_cnt_ff <= start_cnt_ff + 19'h00001;
					end
				end
				ATC_ST_RUN:
					dsp_hold_o <= 1'b0;
			endcase
		end
	end

	// only while holding: a larger limit written after startup must not re-hold
	a_startup_hold: assert property (@(posedge clk_i) disable iff (srst_i)
		start_st_ff == ATC_ST_HOLD && start_cnt_ff < {startup_upper_ff, startup_lower_ff} |=> dsp_hold_o)
		else $error("startup hold released early");
endmodule // atc_top

`default_nettype wire

// *** testbench/atc_fe_model.sv ***
// Purpose: stand-in for the analog offset loops and the angle processor
// Assumes: same clock as the block; the bench picks the codes reported
// Notes:   outputs move only just after a rising edge, as real logic would
`timescale 1ns/1ps
`default_nettype none

module atc_fe_model (
	input wire logic clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire atc_pkg::atc_offset_t coarse_set_i, // coarse code to report
	input wire atc_pkg::atc_offset_t fine_set_i, // fine code to report
	input wire logic evt_req_i, // raise a qualifying event
	output var atc_pkg::atc_offset_t coarse_auto_code_o, // auto coarse code
	output var atc_pkg::atc_offset_t fine_auto_code_o, // auto fine code
	output var logic qualify_evt_o // event, one cycle per request cycle
);
	import atc_pkg::*;
	// registered codes; reset parks them at zero so no stale code leaks out
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			coarse_auto_code_o <= 8'h00;
			fine_auto_code_o <= 8'h00;
			qualify_evt_o <= 1'b0;
		end
		else
		begin
			coarse_auto_code_o <= coarse_set_i;
			fine_auto_code_o <= fine_set_i;
			qualify_evt_o <= evt_req_i;
		end
	end
endmodule // atc_fe_model
`default_nettype wire

// *** testbench/test_afe_trim_timing_control.sv ***
// Purpose: self-checking bench of the front-end trim and timing block
// Assumes: one wait cycle per bus access; unit prescale shortened to 2
// Notes:   startup count keeps bit 16 set so the split count is exercised
`timescale 1ns/1ps
`default_nettype none

module test_afe_trim_timing_control;
	import atc_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int unsigned PS = 2;
	localparam logic [18:0] LIM = 19'h10003;
	typedef struct {
		logic [9:0] a;
		logic [15:0] rv;
		logic [15:0] wd;
		logic [15:0] rb;
	} atc_row_s;
	// address, reset value, write value, readback; 0x124 is unmapped
	atc_row_s rows [9] = '{
		'{10'h110, 16'h0000, 16'h1234, 16'h1234},
		'{10'h114, 16'h0000, 16'h7f85, 16'h0085},
		'{10'h118, 16'h0000, 16'hffff, 16'h80ff},
		'{10'h11c, 16'h0000, 16'ha5a5, 16'ha5a5},
		'{10'h120, 16'h0000, 16'h5a5a, 16'h5a5a},
		'{10'h130, 16'h0000, 16'hc3c3, 16'hc3c3},
		'{10'h134, {13'h0000, LIM[18:16]}, 16'hfff8, 16'h0000},
		'{10'h138, LIM[15:0], 16'h0003, 16'h0003},
		'{10'h124, 16'h0000, 16'hffff, 16'h0000}
	};
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [9:0] addr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] be = 4'hf;
	logic [31:0] rdata;
	logic wreq;
	atc_offset_t cset = 8'h3c;
	atc_offset_t fset = 8'hc3;
	atc_offset_t auto_c;
	atc_offset_t auto_f;
	atc_offset_t dac [2];
	logic aen [2];
	logic evt = 1'b0;
	logic qevt;
	logic sleep = 1'b0;
	logic [5:0] obs;
	int n_mismatch = 0;
	int checks = 0;

	// slow clock keeps the bench at the documented core rate
	always #20 clk_i = ~clk_i;

	atc_fe_model u_fe (.clk_i(clk_i), .srst_i(srst_i), .coarse_set_i(cset), .fine_set_i(fset),
		.evt_req_i(evt), .coarse_auto_code_o(auto_c), .fine_auto_code_o(auto_f), .qualify_evt_o(qevt));

	atc_top #(.PRESCALE(PS), .STARTUP_RESET_CNT(LIM)) u_dut (.clk_i(clk_i), .srst_i(srst_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.coarse_auto_code_i(auto_c), .fine_auto_code_i(auto_f), .qualify_evt_i(qevt),
		.sleep_exit_i(sleep), .gain_update_stb_o(obs[0]), .offset_update_stb_o(obs[1]),
		.coarse_auto_en_o(aen[0]), .fine_auto_en_o(aen[1]), .coarse_offset_dac_o(dac[0]),
		.fine_offset_dac_o(dac[1]), .extrap_active_o(obs[2]), .wake_settling_o(obs[3]),
		.wake_done_o(obs[4]), .dsp_hold_o(obs[5]));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic give_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
			n_mismatch++;
		end
	endtask

	// one bus access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		addr <= a;
		wdata <= {16'h0000, d};
		wr <= w;
		rd <= !w;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (wreq !== 1'b0)
		begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// edges until obs[k] reads v; a hang ends the run
	task automatic wait_for(input int k, input logic v, output int n);
		n = 0;
		while (obs[k] !== v && n < 500)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 500)
		begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// length of the high run of obs[k] starting at this edge
	task automatic run_len(input int k, output int n);
		n = 0;
		while (obs[k] === 1'b1 && n < 70000)
		begin
			n++;
			@(posedge clk_i);
		end
	endtask

	// high samples of obs[k] over a fixed number of edges
	task automatic cnt_hi(input int k, input int cyc, output int n);
		n = 0;
		repeat (cyc)
		begin
			@(posedge clk_i);
			if (obs[k] === 1'b1)
				n++;
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] q;
		int n;
		int s;
		logic [9:0] tad [2] = '{10'h110, 10'h11c};
		logic [15:0] ovv [2] = '{16'h8085, 16'h807f};
		logic [31:0] fex [2] = '{32'hffffff85, 32'h0000007f};
		logic [31:0] aex [2] = '{32'h0000003c, 32'hffffffc3};
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		run_len(5, n);
		chk("startup hold cycles", n, LIM + 1);
		foreach (rows[i])
		begin
			bus(1'b0, rows[i].a, 16'h0000, q);
			chk("reset value", q, {16'h0000, rows[i].rv});
			bus(1'b1, rows[i].a, rows[i].wd, q);
			bus(1'b0, rows[i].a, 16'h0000, q);
			chk("readback", q, {16'h0000, rows[i].rb});
		end
		// both update timers: spacing, restart with a new period, zero stops
		for (int t = 0; t < 2; t++)
		begin
			bus(1'b1, tad[t], 16'h0003, q);
			wait_for(t, 1'b1, n);
			@(posedge clk_i);
			wait_for(t, 1'b1, n);
			chk("strobe spacing", n + 1, 3 * PS);
			bus(1'b1, tad[t], 16'h0005, q);
			wait_for(t, 1'b1, n);
			@(posedge clk_i);
			wait_for(t, 1'b1, n);
			chk("new period spacing", n + 1, 5 * PS);
			bus(1'b1, tad[t], 16'h0000, q);
			repeat (2) @(posedge clk_i);
			cnt_hi(t, 60, n);
			chk("strobes at zero period", n, 0);
		end
		// forced offset codes, then back to the automatic loop
		for (int c = 0; c < 2; c++)
		begin
			bus(1'b1, 10'h114 + 10'(4 * c), ovv[c], q);
			repeat (2) @(posedge clk_i);
			chk("forced dac code", dac[c], fex[c]);
			chk("auto enable", aen[c], 1'b0);
			bus(1'b1, 10'h114 + 10'(4 * c), ovv[c] & 16'h7fff, q);
			repeat (2) @(posedge clk_i);
			chk("auto dac code", dac[c], aex[c]);
			chk("auto enable", aen[c], 1'b1);
		end
		// extrapolator window after one event, then a zero run time
		bus(1'b1, 10'h120, 16'h0002, q);
		@(posedge clk_i);
		evt <= 1'b1;
		@(posedge clk_i);
		evt <= 1'b0;
		wait_for(2, 1'b1, n);
		run_len(2, n);
		chk("extrapolator run", n, 2 * PS);
		bus(1'b1, 10'h120, 16'h0000, q);
		@(posedge clk_i);
		evt <= 1'b1;
		@(posedge clk_i);
		evt <= 1'b0;
		cnt_hi(2, 12, n);
		chk("extrapolator at zero", n, 0);
		// sleep exit settle: zero delay, then five cycles
		for (int d = 0; d < 6; d += 5)
		begin
			bus(1'b1, 10'h130, 16'(d), q);
			@(posedge clk_i);
			sleep <= 1'b1;
			@(posedge clk_i);
			sleep <= 1'b0;
			n = 0;
			s = 0;
			while (obs[4] !== 1'b1 && n < 100)
			begin
				@(posedge clk_i);
				n++;
				if (obs[3] === 1'b1)
					s++;
			end
			chk("wake done seen", obs[4], 1'b1);
			chk("settle cycles", s, d);
		end
		// mid-run reset: hold, bus stall and registers return to reset state
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk("hold after reset", obs[5], 1'b1);
		chk("waitrequest after reset", wreq, 1'b1);
		bus(1'b0, 10'h130, 16'h0000, q);
		chk("settle delay after reset", q, 32'h0000_0000);
		// low byte lane only: the upper byte keeps its reset value
		be <= 4'h1;
		bus(1'b1, 10'h110, 16'habcd, q);
		be <= 4'hf;
		bus(1'b0, 10'h110, 16'h0000, q);
		chk("low lane write", q, 32'h0000_00cd);
		// limit is compared live: cutting it ends the hold on the next edge
		bus(1'b1, 10'h134, 16'h0000, q);
		wait_for(5, 1'b0, n);
		chk("hold end after limit cut", n, 2);
		give_verdict();
	end
endmodule // test_afe_trim_timing_control
`default_nettype wire
